/* File: inc/dsp_regs.svh */
// constants of the serial input port: frame length, clear codes, timing
// assumes inclusion by bare name from the package and the design files
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define DSP_WORD_BITS 24
`define DSP_CNT_RST 5'h00
`define DSP_CNT_LAST 5'h17
`define DSP_CNT_ONE 5'h01

// ------------------------------------------------------------
// clear codes and reset values
// ------------------------------------------------------------
`define DSP_ZERO_CODE 24'h000000
`define DSP_MID_CODE 24'h800000
`define DSP_WORD_RST 24'h000000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DSP_SCLK_MAX_MHZ 25
`define DSP_CLK_MHZ 100
`define DSP_SCLK_MIN_CYC ((`DSP_CLK_MHZ + `DSP_SCLK_MAX_MHZ - 1) / `DSP_SCLK_MAX_MHZ)

`endif

/* File: inc/dsp_pkg.sv */
// types shared by the serial input port files
// assumes dsp_regs.svh sits on the include path
`include "dsp_regs.svh"

package dsp_pkg;

  typedef logic [`DSP_WORD_BITS-1:0] dsp_word_t;

  typedef logic [4:0] dsp_cnt_t;

  typedef enum logic [1:0] {
    DSP_ST_HOLD = 2'b00,
    DSP_ST_LOAD = 2'b01,
    DSP_ST_CLEAR = 2'b10
  } dsp_state_t;

  // control pins that pass the synchroniser together
  typedef struct packed {
    logic load_converter_n;
    logic clear_outputs;
    logic clear_mid;
  } dsp_pins_t;

  // converter-facing result
  typedef struct packed {
    dsp_word_t code;
    logic update;
    logic cleared;
  } dsp_dac_t;

endpackage : dsp_pkg

/* File: core/dsp_link.sv */
// serial-clock side of the input port: shift register, bit count, output launch
// assumes the serial clock idles low and stops outside frames
`timescale 1ns/1ps
`include "dsp_regs.svh"

module dsp_link
  import dsp_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_frame_n,
  input wire logic i_sys_rst,
  input wire logic i_serial_in_line,
  output logic o_serial_out_line,
  output logic o_serial_out_oe,
  output dsp_word_t o_word,
  output logic o_word_tgl
);

  // ------------------------------------------------------------
  // capture on falling edge
  // ------------------------------------------------------------
  dsp_word_t sr_r;
  dsp_word_t sr_nxt;
  dsp_cnt_t cnt_r;
  dsp_cnt_t cnt_nxt;
  dsp_word_t word_r;
  dsp_word_t word_nxt;
  logic tgl_r;
  logic tgl_nxt;
  logic out_r;
  logic out_nxt;
  logic oe_r;

  always_comb begin
    sr_nxt = {sr_r[`DSP_WORD_BITS-2:0], i_serial_in_line};
    cnt_nxt = dsp_cnt_t'(cnt_r + `DSP_CNT_ONE);
    word_nxt = word_r;
    tgl_nxt = tgl_r;
    if (cnt_r == `DSP_CNT_LAST) begin
      cnt_nxt = `DSP_CNT_RST;
      word_nxt = sr_nxt;
      tgl_nxt = ~tgl_r;
    end
  end

  // frame high clears the count, so edges outside a frame never count
  always_ff @(negedge i_sclk or posedge i_frame_n) begin
    if (i_frame_n) begin
      cnt_r <= `DSP_CNT_RST;
      sr_r <= `DSP_WORD_RST;
    end else begin
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
    end
  end

  // word and toggle survive the frame; the core domain picks them up later
  always_ff @(negedge i_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      word_r <= `DSP_WORD_RST;
      tgl_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  // ------------------------------------------------------------
  // launch on rising edge, sampled by the host on falling edge
  // ------------------------------------------------------------
  always_comb begin
    out_nxt = sr_r[`DSP_WORD_BITS-1];
  end

  always_ff @(posedge i_sclk or posedge i_frame_n) begin
    if (i_frame_n) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r <= 1'b1;
    end
  end

  assign o_serial_out_line = out_r;
  assign o_serial_out_oe = oe_r;
  assign o_word = word_r;
  assign o_word_tgl = tgl_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_shift_capture: assert property (
    @(negedge i_sclk) disable iff (i_frame_n)
    1'b1 |=> sr_r[0] == $past(i_serial_in_line)
  ) else $error("input bit not captured on falling edge");

  chk_frame_msb_first: assert property (
    @(negedge i_sclk) disable iff (i_frame_n || i_sys_rst)
    (cnt_r == `DSP_CNT_LAST) |=>
      (word_r == {$past(sr_r[`DSP_WORD_BITS-2:0]), $past(i_serial_in_line)})
      && (tgl_r != $past(tgl_r))
  ) else $error("frame word wrong after last edge");

  chk_no_early_word: assert property (
    @(negedge i_sclk) disable iff (i_frame_n || i_sys_rst)
    (cnt_r != `DSP_CNT_LAST) |=> $stable(tgl_r) && $stable(word_r)
  ) else $error("word handed over before the last edge");

  chk_out_valid: assert property (
    @(negedge i_sclk) disable iff (i_frame_n)
    oe_r |-> out_r == sr_r[`DSP_WORD_BITS-1]
  ) else $error("output bit not valid at falling edge");

endmodule : dsp_link

/* File: core/dsp_port.sv */
// serial input port of the converter: link capture, load and clear control
// assumes the host keeps frame rules and clock rate; link logic runs on i_sclk
`timescale 1ns/1ps
`include "dsp_regs.svh"

module dsp_port
  import dsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_sclk,
  input wire logic i_frame_n,
  input wire logic i_serial_in_line,
  input wire logic i_load_converter_n,
  input wire logic i_clear_outputs,
  input wire logic i_clear_mid,
  output logic o_serial_out_line,
  output logic o_serial_out_oe,
  output dsp_word_t o_input_word,
  output logic o_word_ready,
  output dsp_dac_t o_dac
);

  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  dsp_word_t link_word;
  logic link_tgl;

  dsp_link u_link (
    .i_sclk(i_sclk),
    .i_frame_n(i_frame_n),
    .i_sys_rst(i_sys_rst),
    .i_serial_in_line(i_serial_in_line),
    .o_serial_out_line(o_serial_out_line),
    .o_serial_out_oe(o_serial_out_oe),
    .o_word(link_word),
    .o_word_tgl(link_tgl)
  );

  // ------------------------------------------------------------
  // crossings into the core clock
  // ------------------------------------------------------------
  // the word itself is not synchronised: it is held stable for a whole
  // frame after the toggle, far longer than the three-cycle crossing
  logic [2:0] tgl_sync_r;
  logic [2:0] tgl_sync_nxt;
  dsp_pins_t pin_meta_r;
  dsp_pins_t pin_meta_nxt;
  dsp_pins_t pin_sync_r;
  dsp_pins_t pin_sync_nxt;
  dsp_pins_t pin_raw;
  logic tgl_edge;

  always_comb begin
    pin_raw.load_converter_n = i_load_converter_n;
    pin_raw.clear_outputs = i_clear_outputs;
    pin_raw.clear_mid = i_clear_mid;
    tgl_sync_nxt = tgl_sync_r;
    pin_meta_nxt = pin_meta_r;
    pin_sync_nxt = pin_sync_r;
    if (i_clk_en) begin
      tgl_sync_nxt = {tgl_sync_r[1:0], link_tgl};
      pin_meta_nxt = pin_raw;
      pin_sync_nxt = pin_meta_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tgl_sync_r <= 3'h0;
      pin_meta_r <= 3'h4;
      pin_sync_r <= 3'h4;
    end else begin
      tgl_sync_r <= tgl_sync_nxt;
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
    end
  end

  // stage 0 is the metastable flop; only stages 1 and 2 are compared
  assign tgl_edge = tgl_sync_r[2] ^ tgl_sync_r[1];

  // ------------------------------------------------------------
  // input word register
  // ------------------------------------------------------------
  dsp_word_t in_r;
  dsp_word_t in_nxt;
  logic ready_r;
  logic ready_nxt;

  always_comb begin
    in_nxt = in_r;
    ready_nxt = ready_r;
    if (i_clk_en) begin
      ready_nxt = tgl_edge;
      if (tgl_edge) begin
        in_nxt = link_word;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      in_r <= `DSP_WORD_RST;
      ready_r <= 1'b0;
    end else begin
      in_r <= in_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ------------------------------------------------------------
  // converter register: clear beats load
  // ------------------------------------------------------------
  dsp_state_t st_r;
  dsp_state_t st_nxt;
  dsp_dac_t dac_r;
  dsp_dac_t dac_nxt;
  dsp_word_t clear_code;

  always_comb begin
    clear_code = pin_sync_r.clear_mid ? `DSP_MID_CODE : `DSP_ZERO_CODE;
    st_nxt = st_r;
    if (i_clk_en) begin
      if (pin_sync_r.clear_outputs) begin
        st_nxt = DSP_ST_CLEAR;
      end else if (!pin_sync_r.load_converter_n) begin
        st_nxt = DSP_ST_LOAD;
      end else begin
        st_nxt = DSP_ST_HOLD;
      end
    end
  end

  // load is level sensitive: while held low, fresh words pass straight on
  always_comb begin
    dac_nxt = dac_r;
    if (i_clk_en) begin
      case (st_nxt)
        DSP_ST_CLEAR: begin
          dac_nxt.code = clear_code;
          dac_nxt.update = 1'b0;
          dac_nxt.cleared = 1'b1;
        end
        DSP_ST_LOAD: begin
          dac_nxt.code = in_r;
          dac_nxt.update = 1'b1;
          dac_nxt.cleared = 1'b0;
        end
        DSP_ST_HOLD: begin
          dac_nxt.update = 1'b0;
          dac_nxt.cleared = 1'b0;
        end
        default: begin
          dac_nxt.code = `DSP_WORD_RST;
          dac_nxt.update = 1'b0;
          dac_nxt.cleared = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= DSP_ST_HOLD;
      dac_r <= '0;
    end else begin
      st_r <= st_nxt;
      dac_r <= dac_nxt;
    end
  end

  assign o_input_word = in_r;
  assign o_word_ready = ready_r;
  assign o_dac = dac_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_word_handoff: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && tgl_edge) |=> (in_r == $past(link_word)) && ready_r
  ) else $error("finished frame not moved to input register");

  chk_load_copy: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && !pin_sync_r.load_converter_n && !pin_sync_r.clear_outputs)
      |=> (dac_r.code == $past(in_r)) && dac_r.update && !dac_r.cleared
  ) else $error("load low did not copy input word");

  chk_clear_force: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && pin_sync_r.clear_outputs)
      |=> dac_r.cleared && !dac_r.update
        && (dac_r.code == ($past(pin_sync_r.clear_mid) ? `DSP_MID_CODE : `DSP_ZERO_CODE))
  ) else $error("clear high did not force the clear code");

  chk_clear_level: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && i_clear_outputs) [*3] ##1 i_clk_en |=> dac_r.cleared
  ) else $error("held clear pin not acting on its level");

  chk_hold_stable: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_clk_en && pin_sync_r.load_converter_n && !pin_sync_r.clear_outputs)
      |=> $stable(dac_r.code) && !dac_r.update
  ) else $error("converter code moved without load");

  chk_out_float: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $past(i_frame_n) && i_frame_n |-> !o_serial_out_oe
  ) else $error("serial output driven while frame select high");

  chk_frozen_enable: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_clk_en |=> $stable(dac_r) && $stable(in_r) && $stable(st_r)
  ) else $error("core state moved while clock enable low");

endmodule : dsp_port

/* File: test/dsp_host.sv */
// host model of the port: frame select, serial clock and data line
// assumes one caller at a time; the serial clock stands still between calls
`timescale 1ns/1ps

module dsp_host
  import dsp_pkg::*;
(
  input wire logic i_sdo,
  input wire logic i_oe,
  output logic o_sclk,
  output logic o_frame_n,
  output logic o_serial_in_line
);
  logic [47:0] rd_r;
  logic oe_ok_r;

  // select starts low for a moment so that its rise clears the link state
  // once the design's processes are waiting; a rise at time zero can be lost
  initial begin
    o_sclk = 1'b0;
    o_frame_n = 1'b0;
    o_serial_in_line = 1'b0;
    rd_r = 48'h0;
    oe_ok_r = 1'b1;
    #1;
    o_frame_n = 1'b1;
  end

  // ------------------------------------------------------------
  // one frame; idle keeps select high to send stray edges
  // ------------------------------------------------------------
  // 80 ns period stays under the serial clock ceiling
  task automatic xfer(input logic [47:0] bits, input int n, input logic idle);
    oe_ok_r = 1'b1;
    o_frame_n = idle;
    #40;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b1;
      o_serial_in_line = bits[n-1-i];
      #40;
      o_sclk = 1'b0;
      rd_r = {rd_r[46:0], i_sdo};
      oe_ok_r = oe_ok_r & i_oe;
      #40;
    end
    o_frame_n = 1'b1;
    // released line: never leave the last bit standing
    o_serial_in_line = ~o_serial_in_line;
  endtask : xfer
endmodule : dsp_host

/* File: test/test_dac_serial_input_port.sv */
// self-checking bench of the serial input port
// assumes dsp_host as the far side; no random stimulus
`timescale 1ns/1ps
`include "dsp_regs.svh"

module test_dac_serial_input_port
  import dsp_pkg::*;
;
  logic clk, rst, en, sclk, frame_n, serial_in_line, ld_n, clr, mid, serial_out_line, oe, rdy;
  dsp_word_t word;
  dsp_dac_t dac;
  int mismatches = 0;
  int checked = 0;

  dsp_port dsp_port_inst (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_sclk(sclk),
    .i_frame_n(frame_n), .i_serial_in_line(serial_in_line), .i_load_converter_n(ld_n),
    .i_clear_outputs(clr), .i_clear_mid(mid), .o_serial_out_line(serial_out_line),
    .o_serial_out_oe(oe), .o_input_word(word), .o_word_ready(rdy), .o_dac(dac));

  dsp_host dsp_host_inst (.i_sdo(serial_out_line), .i_oe(oe), .o_sclk(sclk), .o_frame_n(frame_n),
    .o_serial_in_line(serial_in_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input dsp_word_t seen, input dsp_word_t exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_rdy(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk);
      #1;
      got = (rdy === 1'b1);
    end
  endtask : wait_rdy

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(word, `DSP_WORD_RST);
    chk(dac.code, 24'h0);
    chk(dsp_word_t'({rdy, oe, dac.update, dac.cleared}), 24'h0);
  endtask : t_reset

  task automatic t_frame(input dsp_word_t w);
    logic got;
    fork
      dsp_host_inst.xfer({24'h0, w}, 24, 1'b0);
      wait_rdy(400, got);
    join
    settle(1);
    chk(dsp_word_t'(got), 24'h1);
    chk(word, w);
    chk(dsp_word_t'(dsp_host_inst.oe_ok_r), 24'h1);
    chk(dsp_word_t'(oe), 24'h0);
  endtask : t_frame

  // a short frame and stray edges with select high leave no word
  task automatic t_partial;
    logic got;
    fork
      dsp_host_inst.xfer(48'hFFF, 10, 1'b0);
      wait_rdy(200, got);
    join
    chk(dsp_word_t'(got), 24'h0);
    fork
      dsp_host_inst.xfer(48'hFFFFFF, 24, 1'b1);
      wait_rdy(250, got);
    join
    chk(dsp_word_t'(got), 24'h0);
    chk(dsp_word_t'(dsp_host_inst.oe_ok_r), 24'h0);
    t_frame(24'h5A3C96);
  endtask : t_partial

  // 48 edges: two words, and the first comes back out behind it
  task automatic t_long(input dsp_word_t w1, input dsp_word_t w2);
    logic got;
    fork
      dsp_host_inst.xfer({w1, w2}, 48, 1'b0);
      begin
        wait_rdy(400, got);
        chk(word, w1);
        wait_rdy(400, got);
        chk(word, w2);
      end
    join
    chk(dsp_host_inst.rd_r[23:0], w1);
    chk(dsp_host_inst.rd_r[47:24], 24'h0);
  endtask : t_long

  task automatic t_load(input dsp_word_t w);
    @(posedge clk);
    ld_n <= 1'b0;
    en <= 1'b0;
    settle(6);
    chk(dsp_word_t'(dac.update), 24'h0);
    @(posedge clk);
    en <= 1'b1;
    settle(4);
    chk(dac.code, w);
    chk(dsp_word_t'(dac.update), 24'h1);
    @(posedge clk);
    ld_n <= 1'b1;
    settle(4);
    chk(dsp_word_t'(dac.update), 24'h0);
  endtask : t_load

  // clear wins over a held load, and its code outlasts the release
  task automatic t_clear;
    @(posedge clk);
    mid <= 1'b1;
    clr <= 1'b1;
    ld_n <= 1'b0;
    settle(4);
    chk(dac.code, `DSP_MID_CODE);
    chk(dsp_word_t'(dac.cleared), 24'h1);
    @(posedge clk);
    clr <= 1'b0;
    ld_n <= 1'b1;
    settle(4);
    chk(dac.code, `DSP_MID_CODE);
    chk(dsp_word_t'(dac.cleared), 24'h0);
    @(posedge clk);
    mid <= 1'b0;
    clr <= 1'b1;
    settle(4);
    chk(dac.code, `DSP_ZERO_CODE);
    @(posedge clk);
    clr <= 1'b0;
  endtask : t_clear

  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // reset rises on a clock edge: a rise at time zero could miss the link's
  // asynchronous clear and leave its toggle unknown for the whole run
  initial begin
    rst = 1'b0;
    en = 1'b1;
    ld_n = 1'b1;
    clr = 1'b0;
    mid = 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    t_reset;
    t_frame(24'hA5C31E);
    t_partial;
    t_long(24'h800001, 24'h7FFFFE);
    t_load(24'h7FFFFE);
    t_clear;
    wrap_up;
  end

  // whole run is near 1300 cycles; about fifteen times that means a hang
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule : test_dac_serial_input_port
